// [rxl_consts.svh]
`ifndef RXL_CONSTS_SVH
`define RXL_CONSTS_SVH

// apb decode: port select and word offset within a port
`define RXL_ADDR_W        8
`define RXL_PORT_LSB      4
`define RXL_PORT_MSB      5
`define RXL_REG_MSB       3
`define RXL_OFF_CFG       4'h0
`define RXL_OFF_VIOL      4'h4
`define RXL_OFF_STAT      4'h8

// configuration word field positions
`define RXL_CFG_UNIPOLAR  0
`define RXL_CFG_MASKMODE  1
`define RXL_CFG_RCO_SEL   2
`define RXL_CFG_CLK_INV   3
`define RXL_CFG_POS_INV   4
`define RXL_CFG_NEG_INV   5
`define RXL_CFG_ALT_REF   6
`define RXL_CFG_RCO_INV   7
`define RXL_CFG_RESET     8'h00

// status word field positions
`define RXL_STAT_SEEN     0

// nominal line clock rates supplied by the line side, in kHz
`define RXL_DS3_RATE_KHZ  44736
`define RXL_E3_RATE_KHZ   34368
`define RXL_CC_RATE_KHZ   52000

`endif

// [rxl_pkg.sv]
package rxl_pkg;

  // per-port receive configuration held in the bus domain
  typedef struct packed {
    logic alt_ref;
    logic rco_inv;
    logic neg_inv;
    logic pos_inv;
    logic clk_inv;
    logic rco_sel;
    logic overhead_mask_mode;
    logic unipolar_line_mode;
  } rxl_cfg_s;

  // settings that cross into the line domain
  typedef struct packed {
    logic unipolar_line_mode;
    logic overhead_mask_mode;
    logic pos_inv;
    logic neg_inv;
  } rxl_mode_s;

  // sampled and interpreted line stream, one bit time per field
  typedef struct packed {
    logic pos_pulse;
    logic neg_pulse;
    logic data_bit;
    logic data_ok;
    logic viol_hit;
  } rxl_line_s;

endpackage

// [rxl_sync.sv]
`timescale 1ns/1ps
module rxl_sync #(
  parameter int W = 1
) (
  // destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level from the other domain
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } rxl_sync_state_s;

  rxl_sync_state_s st_reg;
  rxl_sync_state_s st_next;

  // not gated by the clock enable: the enable itself crosses through here
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule

// [rxl_sampler.sv]
`timescale 1ns/1ps
module rxl_sampler
  import rxl_pkg::*;
#(
  parameter int VIOL_W = 16
) (
  // reference clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // settings from the bus domain
  input  wire logic              cen_async,
  input  rxl_mode_s              mode_async,
  // line pins
  input  wire logic              pos_in,
  input  wire logic              neg_in,
  // interpreted stream and crossing words
  output rxl_line_s              line,
  output logic [VIOL_W-1:0]      viol_gray,
  output logic                   beat
);

  localparam int MW = $bits(rxl_mode_s) + 1;

  typedef struct packed {
    rxl_line_s         line;
    logic [VIOL_W-1:0] viol_cnt;
    logic [VIOL_W-1:0] viol_gray;
    logic              beat;
  } rxl_smp_state_s;

  rxl_smp_state_s st_reg;
  rxl_smp_state_s st_next;
  logic [MW-1:0]  cfg_sync;
  rxl_mode_s      mode;
  logic           cen;
  logic           pos_s;
  logic           neg_s;
  logic           bip;
  logic           framed;

  rxl_sync #(
    .W(MW)
  ) u_cfg_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     ({cen_async, mode_async}),
    .q     (cfg_sync)
  );

  assign {cen, mode} = cfg_sync;

  always_comb begin
    st_next = st_reg;
    pos_s   = pos_in ^ mode.pos_inv;
    neg_s   = neg_in ^ mode.neg_inv;
    bip     = ~mode.unipolar_line_mode & ~mode.overhead_mask_mode;
    framed  = mode.unipolar_line_mode | mode.overhead_mask_mode;
    if (cen) begin
      st_next.beat           = ~st_reg.beat;
      st_next.line.pos_pulse = bip & pos_s; // RULE5
      st_next.line.neg_pulse = bip & neg_s; // RULE6
      st_next.line.data_bit  = framed & pos_s; // RULE7
      st_next.line.data_ok   = framed & ~(mode.overhead_mask_mode & neg_s); // RULE11
      st_next.line.viol_hit  = mode.unipolar_line_mode & ~mode.overhead_mask_mode & neg_s;
      if (st_next.line.viol_hit) begin
        st_next.viol_cnt = st_reg.viol_cnt + 1'b1; // RULE10
      end
      st_next.viol_gray = st_next.viol_cnt ^ (st_next.viol_cnt >> 1);
    end
  end

  // sampling edge is the rising edge of the already inverted reference
  always_ff @(posedge ref_clk or negedge rst_n) begin // RULE8
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign line      = st_reg.line;
  assign viol_gray = st_reg.viol_gray;
  assign beat      = st_reg.beat;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_pos_pulse_map: assert property ( // RULE5
    cen && bip |=> line.pos_pulse == $past(pos_s) && !line.data_ok)
    else $error("positive pulse does not follow sampled input");

  a_neg_pulse_map: assert property ( // RULE6
    cen && bip |=> line.neg_pulse == $past(neg_s) && !line.viol_hit)
    else $error("negative pulse does not follow sampled input");

  a_data_stream_map: assert property ( // RULE7
    cen && framed |=> line.data_bit == $past(pos_s) && !line.pos_pulse && !line.neg_pulse)
    else $error("unencoded bit does not follow data input");

  a_mask_bit_drop: assert property ( // RULE11
    cen && mode.overhead_mask_mode && neg_s |=> !line.data_ok && !line.viol_hit)
    else $error("masked overhead bit was not dropped");

  a_viol_count_step: assert property ( // RULE10
    cen && mode.unipolar_line_mode && !mode.overhead_mask_mode && neg_s
    |=> st_reg.viol_cnt == $past(st_reg.viol_cnt) + 1'b1)
    else $error("violation counter missed a count");

  a_viol_count_hold: assert property ( // RULE10
    cen && !(mode.unipolar_line_mode && !mode.overhead_mask_mode && neg_s)
    |=> $stable(st_reg.viol_cnt))
    else $error("violation counter moved without a violation");

  a_gray_one_step: assert property ( // RULE10
    1'b1 |=> $countones(st_reg.viol_gray ^ $past(st_reg.viol_gray)) <= 1)
    else $error("gray count changed more than one bit");

  a_freeze_hold: assert property (
    !cen |=> $stable(st_reg))
    else $error("line state moved while frozen");

  c_viol_seen: cover property (cen && line.viol_hit ##1 line.viol_hit);
  c_mask_seen: cover property (mode.overhead_mask_mode && line.data_ok ##1 !line.data_ok);

endmodule

// [rxl_top.sv]
`timescale 1ns/1ps
`include "rxl_consts.svh"

// Notes on behaviour
// [RULE1] Both line inputs of a port are sampled against that port's receive line clock by default.
// [RULE2] Software may flag the receive line clock as timing reference for other serial signals.
// [RULE3] Each port can invert its incoming receive line clock before it is used for sampling.
// [RULE4] The line side supplies 44.736 MHz for DS3, 34.368 MHz for E3 and 52 MHz clear channel.
// [RULE5] In bipolar codes outside mask mode a sampled high on the positive input is a plus pulse.
// [RULE6] In bipolar codes outside mask mode a sampled high on the negative input is a minus pulse.
// [RULE7] In unipolar or mask mode the positive input carries the plain receive bit stream.
// [RULE8] Inputs are taken on the rising reference edge, or the falling edge when it is inverted.
// [RULE9] Software picks line clock input or clock output as reference and can invert each input.
// [RULE10] In unipolar mode without masking each high violation sample adds one to a counter.
// [RULE11] In mask mode a high on the second input marks the bit as overhead and it is dropped.
// [RULE12] Every port keeps its own line mode, reference choice and polarity settings.
module rxl_top
  import rxl_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int VIOL_W = 16
) (
  // bus clock, reset and enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    pclk_en,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`RXL_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // line pins, one bit per port
  input  wire logic [NPORTS-1:0]       rx_line_clock_in,
  input  wire logic [NPORTS-1:0]       rx_positive_pulse_in,
  input  wire logic [NPORTS-1:0]       rx_negative_pulse_in,
  // clocks and streams toward decoder and framer
  output logic [NPORTS-1:0]            rx_clock_out,
  output logic [NPORTS-1:0]            rx_ref_clock,
  output rxl_line_s [NPORTS-1:0]       rx_line,
  output logic [NPORTS-1:0]            rx_alt_ref_sel
);

  typedef struct packed {
    rxl_cfg_s [NPORTS-1:0] cfg;
    logic [NPORTS-1:0]     seen;
    logic [NPORTS-1:0]     beat_d;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  rd_ok;
  } rxl_top_state_s;

  rxl_top_state_s                  st_reg;
  rxl_top_state_s                  st_next;
  logic [NPORTS-1:0][VIOL_W-1:0]   viol_bin;
  logic [NPORTS-1:0]               beat_sync;
  logic [1:0]                      port_idx;
  logic [`RXL_REG_MSB:0]           reg_off;
  logic                            hit;
  logic                            fire;
  logic [31:0]                     rd_word;
  logic [NPORTS-1:0]               clr;

  function automatic logic [31:0] cfg_to_word(input rxl_cfg_s c);
    logic [31:0] w;
    w                     = 32'h0000_0000;
    w[`RXL_CFG_UNIPOLAR]  = c.unipolar_line_mode;
    w[`RXL_CFG_MASKMODE]  = c.overhead_mask_mode;
    w[`RXL_CFG_RCO_SEL]   = c.rco_sel;
    w[`RXL_CFG_CLK_INV]   = c.clk_inv;
    w[`RXL_CFG_POS_INV]   = c.pos_inv;
    w[`RXL_CFG_NEG_INV]   = c.neg_inv;
    w[`RXL_CFG_ALT_REF]   = c.alt_ref;
    w[`RXL_CFG_RCO_INV]   = c.rco_inv;
    return w;
  endfunction

  function automatic rxl_cfg_s word_to_cfg(input logic [31:0] w);
    rxl_cfg_s c;
    c                    = rxl_cfg_s'(`RXL_CFG_RESET);
    c.unipolar_line_mode = w[`RXL_CFG_UNIPOLAR];
    c.overhead_mask_mode = w[`RXL_CFG_MASKMODE];
    c.rco_sel            = w[`RXL_CFG_RCO_SEL];
    c.clk_inv            = w[`RXL_CFG_CLK_INV];
    c.pos_inv            = w[`RXL_CFG_POS_INV];
    c.neg_inv            = w[`RXL_CFG_NEG_INV];
    c.alt_ref            = w[`RXL_CFG_ALT_REF];
    c.rco_inv            = w[`RXL_CFG_RCO_INV];
    return c;
  endfunction

  function automatic logic [VIOL_W-1:0] gray_to_bin(input logic [VIOL_W-1:0] g);
    logic [VIOL_W-1:0] b;
    b = '0;
    for (int k = 0; k < VIOL_W; k++) begin
      b[k] = ^(g >> k);
    end
    return b;
  endfunction

  // one independent line front end per port
  for (genvar i = 0; i < NPORTS; i++) begin : g_port // RULE12
    logic [VIOL_W-1:0] gray_async;
    logic              beat_async;
    logic [VIOL_W-1:0] gray_sync;
    rxl_mode_s         mode;

    assign rx_clock_out[i] = rx_line_clock_in[i] ^ st_reg.cfg[i].rco_inv;

    // clock mux is static: change rco_sel or clk_inv only while the port is idle,
    // since a switch can produce a runt edge on the sampling reference
    assign rx_ref_clock[i] = (st_reg.cfg[i].rco_sel ? rx_clock_out[i] // RULE1 RULE9
                                                    : rx_line_clock_in[i])
                             ^ st_reg.cfg[i].clk_inv; // RULE3 RULE8

    assign rx_alt_ref_sel[i] = st_reg.cfg[i].alt_ref; // RULE2

    assign mode.unipolar_line_mode = st_reg.cfg[i].unipolar_line_mode;
    assign mode.overhead_mask_mode = st_reg.cfg[i].overhead_mask_mode;
    assign mode.pos_inv            = st_reg.cfg[i].pos_inv; // RULE9
    assign mode.neg_inv            = st_reg.cfg[i].neg_inv; // RULE9

    rxl_sampler #(
      .VIOL_W(VIOL_W)
    ) u_sampler (
      .ref_clk    (rx_ref_clock[i]),
      .rst_n      (presetn),
      .cen_async  (pclk_en),
      .mode_async (mode),
      .pos_in     (rx_positive_pulse_in[i]),
      .neg_in     (rx_negative_pulse_in[i]),
      .line       (rx_line[i]),
      .viol_gray  (gray_async),
      .beat       (beat_async)
    );

    // gray count changes at most one bit per line edge, so a two-stage sync is safe
    rxl_sync #(
      .W(VIOL_W + 1)
    ) u_back_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({beat_async, gray_async}),
      .q     ({beat_sync[i], gray_sync})
    );

    assign viol_bin[i] = gray_to_bin(gray_sync);
  end

  // decode: paddr[5:4] picks the port, paddr[3:0] the word
  always_comb begin
    port_idx = paddr[`RXL_PORT_MSB:`RXL_PORT_LSB];
    reg_off  = paddr[`RXL_REG_MSB:0];
    hit      = (paddr[`RXL_ADDR_W-1:`RXL_PORT_MSB+1] == '0)
               && (int'(port_idx) < NPORTS)
               && ((reg_off == `RXL_OFF_CFG)
                   || (reg_off == `RXL_OFF_VIOL)
                   || (reg_off == `RXL_OFF_STAT));
    rd_word  = 32'h0000_0000;
    if (hit) begin
      case (reg_off)
        `RXL_OFF_CFG: begin
          rd_word = cfg_to_word(st_reg.cfg[port_idx]);
        end
        `RXL_OFF_VIOL: begin
          rd_word[VIOL_W-1:0] = viol_bin[port_idx];
        end
        `RXL_OFF_STAT: begin
          rd_word[`RXL_STAT_SEEN] = st_reg.seen[port_idx];
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  assign fire = psel && penable && st_reg.rd_ok;

  always_comb begin
    st_next = st_reg;
    clr     = '0;
    if (pclk_en) begin
      st_next.beat_d = beat_sync;
      if (fire && pwrite && hit && (reg_off == `RXL_OFF_STAT)) begin
        clr[port_idx] = pwdata[`RXL_STAT_SEEN];
      end
      // a line edge in the clearing cycle keeps the flag set
      st_next.seen = (st_reg.seen & ~clr) | (beat_sync ^ st_reg.beat_d);
      if (psel && !st_reg.rd_ok) begin
        st_next.prdata  = rd_word;
        st_next.pslverr = ~hit;
        st_next.rd_ok   = 1'b1;
      end else if (fire) begin
        st_next.rd_ok = 1'b0;
        if (pwrite && hit && (reg_off == `RXL_OFF_CFG)) begin
          st_next.cfg[port_idx] = word_to_cfg(pwdata); // RULE12
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready  = psel && penable && st_reg.rd_ok && pclk_en;
  assign prdata  = st_reg.prdata;
  assign pslverr = st_reg.pslverr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_apb_zero_wait: assert property (
    psel && !penable && pclk_en && !st_reg.rd_ok ##1 psel && penable && pclk_en |-> pready)
    else $error("access phase after a clean setup was not ready");

  a_cfg_write_takes: assert property ( // RULE12
    pready && pwrite && hit && (reg_off == `RXL_OFF_CFG)
    |=> st_reg.cfg[$past(port_idx)] == word_to_cfg($past(pwdata)))
    else $error("configuration write did not land");

  a_unmapped_error: assert property (
    pready && !hit |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address answered without error");

  a_alt_ref_follow: assert property ( // RULE2
    pready && pwrite && hit && (reg_off == `RXL_OFF_CFG) && (port_idx == 2'h0)
    |=> rx_alt_ref_sel[0] == $past(pwdata[`RXL_CFG_ALT_REF]))
    else $error("alternate reference flag does not follow its field");

  a_seen_sticky: assert property (
    pclk_en && st_reg.seen[0] && !clr[0] |=> st_reg.seen[0])
    else $error("seen flag dropped without a clear");

  c_cfg_write: cover property (pready && pwrite && hit && (reg_off == `RXL_OFF_CFG));
  c_viol_read: cover property (pready && !pwrite && (reg_off == `RXL_OFF_VIOL) && prdata != '0);

endmodule

// [rxl_liu_model.sv]
`timescale 1ns/1ps
module rxl_liu_model #(
  parameter int  NPORTS  = 4,
  parameter real HALF_NS = 7.5
) (
  // hold both pulse lines low
  input  wire logic         quiet,
  // recovered clock and data toward the device
  output logic [NPORTS-1:0] line_clk,
  output logic [NPORTS-1:0] pos,
  output logic [NPORTS-1:0] neg
);
  integer seed = 32'h51a7;

  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    // the bench runs faster than the nominal line rates to keep runs short
    initial begin
      line_clk[g] = 1'b0;
      pos[g] = 1'b0;
      neg[g] = 1'b0;
      #(1.3 + 2.9 * g);
      forever #(HALF_NS) line_clk[g] = ~line_clk[g];
    end
    // data moves mid-way between edges so either sampling edge sees it settled
    always @(line_clk[g]) begin
      #(HALF_NS / 2);
      pos[g] = quiet ? 1'b0 : 1'($random(seed));
      neg[g] = quiet ? 1'b0 : 1'($random(seed));
    end
  end
endmodule

// [rx_line_input_stage_bench.sv]
`timescale 1ns/1ps
module rx_line_input_stage_bench;
  import rxl_pkg::*;
  localparam int NP = 4;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               pclk_en = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               quiet = 1'b1;
  logic [NP-1:0]      lclk;
  logic [NP-1:0]      lpos;
  logic [NP-1:0]      lneg;
  logic [NP-1:0]      rco;
  logic [NP-1:0]      rref;
  logic [NP-1:0]      alt;
  rxl_line_s [NP-1:0] rline;
  logic [7:0]         cfg_sh [NP];
  logic [7:0]         corner [NP] = '{8'h03, 8'h02, 8'h3c, 8'h8d};
  logic [NP-1:0]      chk_on = '0;
  int                 hits [NP];
  int                 n_mismatch = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  integer             seed = 32'h3e50;

  always #20 pclk = ~pclk;

  rxl_top #(.NPORTS(NP), .VIOL_W(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line_clock_in(lclk), .rx_positive_pulse_in(lpos),
    .rx_negative_pulse_in(lneg), .rx_clock_out(rco), .rx_ref_clock(rref),
    .rx_line(rline), .rx_alt_ref_sel(alt));

  rxl_liu_model #(.NPORTS(NP)) i_liu (.quiet(quiet), .line_clk(lclk), .pos(lpos), .neg(lneg));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at the combinational ready while it is settled, and take the answer at that same falling edge
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(negedge pclk);
    end
    if (n == 50) check("pready", 1'b0, 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check("prdata", r, x);
    check("pslverr", e, xe);
  endtask

  // upper half is the mask of fields that the mode defines, lower half their values
  function automatic logic [9:0] expect_line(input logic [7:0] c, input logic p, input logic n);
    if (c[1]) return {5'h1f, 2'h0, p, ~n, 1'h0};
    if (c[0]) return {5'h07, 2'h0, p, 1'h1, n};
    return {5'h1a, p, n, 3'h0};
  endfunction

  for (genvar g = 0; g < NP; g++) begin : g_mon
    always @(lclk[g]) begin
      logic [7:0] c;
      logic       p;
      logic       n;
      logic [9:0] e;
      c = cfg_sh[g];
      if (lclk[g] === ~(c[3] ^ (c[2] & c[7]))) begin
        p = lpos[g] ^ c[4];
        n = lneg[g] ^ c[5];
        e = expect_line(c, p, n);
        if (chk_on[g] && c[0] && !c[1] && n) hits[g]++;
        #2;
        if (chk_on[g]) begin
          check("rx_ref_clock", rref[g], 1'b1);
          check("rx_clock_out", rco[g], lclk[g] ^ c[7]);
          check("rx_line", rline[g] & e[9:5], e[4:0]);
        end
      end
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  c;
    logic [15:0] v0 [NP];
    for (int p = 0; p < NP; p++) cfg_sh[p] = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < NP; p++) rd_chk(8'(16 * p), 32'h0000_0000, 1'b0);
    check("alt_ref", alt, 4'h0);
    rd_chk(8'h0c, 32'h0000_0000, 1'b1);
    rd_chk(8'h40, 32'h0000_0000, 1'b1);
    quiet <= 1'b0;
    // pass 0 keeps defaults, pass 1 hand-picked corners, then random settings per port
    for (int it = 0; it < 14; it++) begin
      chk_on <= '0;
      for (int p = 0; p < NP; p++) begin
        c = (it == 0) ? 8'h00 : (it == 1) ? corner[p] : 8'($random(seed));
        cfg_sh[p] = c;
        wr(8'(16 * p), {24'h00_0000, c});
        rd_chk(8'(16 * p), {24'h00_0000, c}, 1'b0);
      end
      for (int p = 0; p < NP; p++) check("alt_ref", alt[p], cfg_sh[p][6]);
      repeat (15) @(posedge pclk);
      chk_on <= '1;
      repeat (40) @(posedge pclk);
    end
    // every port's line clock has run since reset, so its seen flag must be up
    for (int p = 0; p < NP; p++) rd_chk(8'(16 * p + 8), 32'h0000_0001, 1'b0);
    // violation counting in unipolar mode, line held quiet around the counter reads
    quiet <= 1'b1;
    chk_on <= '0;
    for (int p = 0; p < NP; p++) begin
      c = 8'h01 | (8'($random(seed)) & 8'hdc);
      cfg_sh[p] = c;
      wr(8'(16 * p), {24'h00_0000, c});
    end
    repeat (15) @(posedge pclk);
    for (int p = 0; p < NP; p++) begin
      apb(1'b0, 8'(16 * p + 4), 32'h0000_0000, r, e);
      v0[p] = r[15:0];
      hits[p] = 0;
    end
    chk_on <= '1;
    quiet <= 1'b0;
    repeat (200) @(posedge pclk);
    quiet <= 1'b1;
    repeat (15) @(posedge pclk);
    pclk_en <= 1'b0;
    fork
      rd_chk(8'h00, {24'h00_0000, cfg_sh[0]}, 1'b0);
      begin
        repeat (4) @(posedge pclk);
        pclk_en <= 1'b1;
      end
    join
    for (int p = 0; p < NP; p++) begin
      apb(1'b0, 8'(16 * p + 4), 32'h0000_0000, r, e);
      check("viol_count", 16'(r[15:0] - v0[p]), hits[p][15:0]);
    end
    report_and_stop();
  end
endmodule
